// *** rcs_pkg.sv ***
package rcs_pkg;
  // System clock rate
  localparam int CLK_MHZ = 100;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_AT_NORM = 8'h1e;
  localparam logic [7:0] IDX_AT_FAST = 8'h1f;
  localparam logic [7:0] IDX_STRAP_A = 8'h34;
  localparam logic [7:0] IDX_STRAP_B = 8'h35;
  localparam logic [7:0] IDX_RANGE_LO = 8'h40;
  localparam logic [7:0] IDX_RANGE_HI = 8'h41;
  localparam logic [7:0] IDX_RST_CTRL = 8'h42;
  localparam logic [7:0] IDX_RST_CAUSE = 8'h43;
  // Field positions in the strap registers
  localparam int A_PINOUT = 0;
  localparam int A_RTC = 2;
  localparam int A_AUX = 3;
  localparam int A_SUPPLY = 5;
  localparam int B_PARITY = 1;
  localparam int B_KBC = 5;
  localparam int B_NORMAL = 6;
  localparam int B_ROM = 7;
  // Field positions in reset control and cause
  localparam int CTRL_SOFT_RST = 0;
  localparam int CAUSE_POWER = 0;
  localparam int CAUSE_KBC = 1;
  localparam int CAUSE_SHUTDOWN = 2;
  localparam int CAUSE_SOFT = 3;
  // Reset values
  localparam logic [2:0] AT_NORM_RST = 3'h0;
  localparam logic [2:0] AT_FAST_RST = 3'h7;
  localparam logic [7:0] RANGE_LO_RST = 8'hff;
  localparam logic [7:0] RANGE_HI_RST = 8'h00;
  localparam logic [3:0] CAUSE_RST = 4'h1;
  // Local reset pulse: least time, rounded up to whole cycles
  localparam int RST_PULSE_NS = 1000;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  // Strap levels, one bit per strap pin
  typedef struct packed {
    logic strap_rom_select;
    logic strap_normal_b;
    logic strap_kbc_enable;
    logic strap_parity_enable;
    logic strap_supply_level;
    logic strap_mode_aux;
    logic strap_rtc_enable;
    logic strap_pinout_mode;
  } rcs_strap_t;
  // Levels set by the board pulls
  localparam rcs_strap_t STRAP_DEFAULT = 8'h3e;
  // Local reset sequencer
  typedef enum logic [1:0] {
    RST_HOLD = 2'b00,
    RST_PULSE = 2'b01,
    RST_RUN = 2'b10
  } rcs_rst_state_t;
  // Half period of the expansion-bus clock in system cycles
  function automatic logic [7:0] at_half(input logic [2:0] sel);
    case (sel)
      3'h0: at_half = 8'h08;
      3'h1: at_half = 8'h07;
      3'h2: at_half = 8'h06;
      3'h3: at_half = 8'h05;
      3'h4: at_half = 8'h04;
      3'h5: at_half = 8'h03;
      3'h6: at_half = 8'h02;
      default: at_half = 8'h01;
    endcase
  endfunction
endpackage

// *** rcs_top.sv ***
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
// How it works
// - Power-good drives bus and local resets
// - Fast keyboard reset and shutdown reset locally
// - Bus clock is half the double-rate clock
// - Keyboard clock is oscillator halved, power on
// - Accesses inside programmed range select fast speed
// - Eight expansion clock rates, changeable while running
// - Channel-0 strap latched as pinout mode
// - Channel-2 strap latched as RTC enable
// - Channel-5 strap latched as keyboard enable
// - Channel-1 strap latched as parity enable
// - Remaining straps latched into status bits
module rcs_top (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_power_good_in,
  input wire logic i_double_rate_clock_in,
  input wire logic i_ref_oscillator_in,
  input wire rcs_pkg::rcs_strap_t i_straps,
  input wire logic i_cpu_access,
  input wire logic [23:0] i_cpu_addr,
  input wire logic i_kbc_fast_reset,
  input wire logic i_shutdown_cycle,
  output logic o_bus_reset,
  output logic o_local_cpu_reset_out,
  output logic o_bus_clock_out,
  output logic o_kbc_half_osc_clock,
  output logic o_expansion_bus_clock,
  output rcs_pkg::rcs_strap_t o_strap_cfg
);

  // Chip reset apart from clock dividers and strap latch: external reset or power not good
  logic sys_rst;
  assign sys_rst = i_rst | ~i_power_good_in;

  // Bus request decode
  logic wb_req; // Request waiting for its answer
  logic [7:0] wb_idx; // Register index from the byte address
  logic wb_wr; // Write that takes effect this edge
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wb_idx = i_wb_adr[9:2];
  assign wb_wr = wb_req & i_wb_we & i_wb_sel[0];

  // Software-visible registers
  logic [2:0] at_norm, next_at_norm; // Normal expansion clock rate
  logic [2:0] at_fast, next_at_fast; // Fast expansion clock rate
  logic [7:0] range_lo, next_range_lo; // Fast range lower bound, addr[23:16]
  logic [7:0] range_hi, next_range_hi; // Fast range upper bound, addr[23:16]
  logic [3:0] cause, next_cause; // Sticky reset causes
  logic soft_rst, next_soft_rst; // One-cycle software reset request
  logic [31:0] next_wb_dat;
  logic next_wb_ack;

  // Local reset events, valid only while running
  logic ev_kbc, ev_shut;
  assign ev_kbc = i_kbc_fast_reset;
  assign ev_shut = i_shutdown_cycle;
  // Sequencer state, declared here because cause logic reads it
  rcs_pkg::rcs_rst_state_t rst_state, next_rst_state;

  // Register writes, reads and the bus answer
  always_comb begin
    next_at_norm = at_norm;
    next_at_fast = at_fast;
    next_range_lo = range_lo;
    next_range_hi = range_hi;
    next_cause = cause;
    next_soft_rst = 1'b0;
    next_wb_ack = wb_req;
    next_wb_dat = 32'h0000_0000;
    // Read data; unmapped indices read zero
    case (wb_idx)
      rcs_pkg::IDX_AT_NORM: next_wb_dat[2:0] = at_norm;
      rcs_pkg::IDX_AT_FAST: next_wb_dat[2:0] = at_fast;
      rcs_pkg::IDX_STRAP_A: begin
        next_wb_dat[rcs_pkg::A_PINOUT] = o_strap_cfg.strap_pinout_mode;
        next_wb_dat[rcs_pkg::A_RTC] = o_strap_cfg.strap_rtc_enable;
        next_wb_dat[rcs_pkg::A_AUX] = o_strap_cfg.strap_mode_aux;
        next_wb_dat[rcs_pkg::A_SUPPLY] = o_strap_cfg.strap_supply_level;
      end
      rcs_pkg::IDX_STRAP_B: begin
        next_wb_dat[rcs_pkg::B_PARITY] = o_strap_cfg.strap_parity_enable;
        next_wb_dat[rcs_pkg::B_KBC] = o_strap_cfg.strap_kbc_enable;
        next_wb_dat[rcs_pkg::B_NORMAL] = o_strap_cfg.strap_normal_b;
        next_wb_dat[rcs_pkg::B_ROM] = o_strap_cfg.strap_rom_select;
      end
      rcs_pkg::IDX_RANGE_LO: next_wb_dat[7:0] = range_lo;
      rcs_pkg::IDX_RANGE_HI: next_wb_dat[7:0] = range_hi;
      rcs_pkg::IDX_RST_CAUSE: next_wb_dat[3:0] = cause;
      default: next_wb_dat = 32'h0000_0000;
    endcase
    if (!wb_req || i_wb_we) begin
      next_wb_dat = 32'h0000_0000;
    end
    // Writes; strap registers are read only
    if (wb_wr) begin
      case (wb_idx)
        rcs_pkg::IDX_AT_NORM: next_at_norm = i_wb_dat[2:0];
        rcs_pkg::IDX_AT_FAST: next_at_fast = i_wb_dat[2:0];
        rcs_pkg::IDX_RANGE_LO: next_range_lo = i_wb_dat[7:0];
        rcs_pkg::IDX_RANGE_HI: next_range_hi = i_wb_dat[7:0];
        rcs_pkg::IDX_RST_CTRL: next_soft_rst = i_wb_dat[rcs_pkg::CTRL_SOFT_RST];
        rcs_pkg::IDX_RST_CAUSE: next_cause = cause & ~i_wb_dat[3:0];
        default: next_cause = cause;
      endcase
    end
    // Hardware sets after the clear so a coincident event wins
    if (rst_state == rcs_pkg::RST_RUN) begin
      if (ev_kbc) begin
        next_cause[rcs_pkg::CAUSE_KBC] = 1'b1;
      end
      if (ev_shut) begin
        next_cause[rcs_pkg::CAUSE_SHUTDOWN] = 1'b1;
      end
      if (soft_rst) begin
        next_cause[rcs_pkg::CAUSE_SOFT] = 1'b1;
      end
    end
  end

  // Register state; power loss returns it to defaults
  always_ff @(posedge i_sys_clk) begin
    if (sys_rst) begin
      at_norm <= rcs_pkg::AT_NORM_RST;
      at_fast <= rcs_pkg::AT_FAST_RST;
      range_lo <= rcs_pkg::RANGE_LO_RST;
      range_hi <= rcs_pkg::RANGE_HI_RST;
      cause <= rcs_pkg::CAUSE_RST;
      soft_rst <= 1'b0;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      at_norm <= next_at_norm;
      at_fast <= next_at_fast;
      range_lo <= next_range_lo;
      range_hi <= next_range_hi;
      cause <= next_cause;
      soft_rst <= next_soft_rst;
      o_wb_ack <= next_wb_ack;
      o_wb_dat <= next_wb_dat;
    end
  end

  // Reset sequencer counters
  logic [7:0] rst_cnt, next_rst_cnt; // Cycles left in the local pulse
  logic next_bus_reset, next_local_reset;

  // Local reset pulse after power-good and on internal events
  always_comb begin
    next_rst_state = rst_state;
    next_rst_cnt = rst_cnt;
    next_bus_reset = ~i_power_good_in;
    case (rst_state)
      rcs_pkg::RST_HOLD: begin
        next_rst_state = rcs_pkg::RST_PULSE;
        next_rst_cnt = 8'(rcs_pkg::RST_PULSE_CYC - 1);
      end
      rcs_pkg::RST_PULSE: begin
        if (rst_cnt == 8'h00) begin
          next_rst_state = rcs_pkg::RST_RUN;
        end else begin
          next_rst_cnt = rst_cnt - 8'h01;
        end
      end
      rcs_pkg::RST_RUN: begin
        if (ev_kbc || ev_shut || soft_rst) begin
          next_rst_state = rcs_pkg::RST_PULSE;
          next_rst_cnt = 8'(rcs_pkg::RST_PULSE_CYC - 1);
        end
      end
      default: next_rst_state = rcs_pkg::RST_HOLD;
    endcase
    next_local_reset = (next_rst_state != rcs_pkg::RST_RUN);
  end

  // Sequencer registers; held in reset while power is bad
  always_ff @(posedge i_sys_clk) begin
    if (sys_rst) begin
      rst_state <= rcs_pkg::RST_HOLD;
      rst_cnt <= 8'h00;
      o_local_cpu_reset_out <= 1'b1;
      o_bus_reset <= 1'b1;
    end else begin
      rst_state <= next_rst_state;
      rst_cnt <= next_rst_cnt;
      o_local_cpu_reset_out <= next_local_reset;
      o_bus_reset <= next_bus_reset;
    end
  end

  // Straps: follow the pins while power is bad, frozen afterwards
  rcs_pkg::rcs_strap_t next_strap_cfg;
  always_comb begin
    next_strap_cfg = o_strap_cfg;
    if (!i_power_good_in) begin
      next_strap_cfg = i_straps;
    end
  end

  // Capture is clocked so the last pre-release level is held
  always_ff @(posedge i_sys_clk) begin
    if (i_rst && i_power_good_in) begin
      o_strap_cfg <= rcs_pkg::STRAP_DEFAULT;
    end else begin
      o_strap_cfg <= next_strap_cfg;
    end
  end

  // Input clock history for edge detection
  logic drc_prev, osc_prev;
  logic next_bus_clk, next_kbc_clk;

  // Dividers by two on rising edges of each input clock
  always_comb begin
    next_bus_clk = o_bus_clock_out;
    next_kbc_clk = o_kbc_half_osc_clock;
    if (i_double_rate_clock_in && !drc_prev) begin
      next_bus_clk = ~o_bus_clock_out;
    end
    if (i_ref_oscillator_in && !osc_prev) begin
      next_kbc_clk = ~o_kbc_half_osc_clock;
    end
    // No keyboard clock without power
    if (!i_power_good_in) begin
      next_kbc_clk = 1'b0;
    end
  end

  // Bus clock keeps running while power is bad so the core can reset
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      drc_prev <= 1'b0;
      osc_prev <= 1'b0;
      o_bus_clock_out <= 1'b0;
      o_kbc_half_osc_clock <= 1'b0;
    end else begin
      drc_prev <= i_double_rate_clock_in;
      osc_prev <= i_ref_oscillator_in;
      o_bus_clock_out <= next_bus_clk;
      o_kbc_half_osc_clock <= next_kbc_clk;
    end
  end

  // Expansion clock generator state
  logic at_speed_fast, next_at_speed_fast; // Last access fell in the range
  logic [7:0] at_cnt, next_at_cnt; // Cycles left in this phase
  logic [7:0] at_hold, next_at_hold; // Half period of the current period
  logic next_exp_clk;
  logic in_range;
  assign in_range = (i_cpu_addr[23:16] >= range_lo) && (i_cpu_addr[23:16] <= range_hi);

  // Rate is chosen only when a new period starts, never mid-phase
  always_comb begin
    logic [7:0] new_half;
    new_half = rcs_pkg::at_half(at_speed_fast ? at_fast : at_norm);
    next_at_speed_fast = at_speed_fast;
    next_at_hold = at_hold;
    next_exp_clk = o_expansion_bus_clock;
    next_at_cnt = at_cnt - 8'h01;
    if (i_cpu_access) begin
      next_at_speed_fast = in_range;
    end
    if (at_cnt == 8'h00) begin
      next_exp_clk = ~o_expansion_bus_clock;
      if (!o_expansion_bus_clock) begin
        // Rising edge starts a period: take the new rate
        next_at_hold = new_half;
        next_at_cnt = new_half - 8'h01;
      end else begin
        // Low phase repeats the high phase length
        next_at_cnt = at_hold - 8'h01;
      end
    end
  end

  // Expansion clock registers
  always_ff @(posedge i_sys_clk) begin
    if (sys_rst) begin
      at_speed_fast <= 1'b0;
      at_cnt <= 8'h00;
      at_hold <= 8'h01;
      o_expansion_bus_clock <= 1'b0;
    end else begin
      at_speed_fast <= next_at_speed_fast;
      at_cnt <= next_at_cnt;
      at_hold <= next_at_hold;
      o_expansion_bus_clock <= next_exp_clk;
    end
  end

endmodule

// *** rcs_checker.sv ***
`timescale 1ns/1ps
module rcs_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_power_good_in,
  input wire logic i_double_rate_clock_in,
  input wire logic i_ref_oscillator_in,
  input wire rcs_pkg::rcs_strap_t i_straps,
  input wire logic i_kbc_fast_reset,
  input wire logic o_bus_reset,
  input wire logic o_local_cpu_reset_out,
  input wire logic o_bus_clock_out,
  input wire logic o_kbc_half_osc_clock,
  input wire logic o_expansion_bus_clock,
  input wire rcs_pkg::rcs_strap_t o_strap_cfg
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Previous expansion clock level
  logic xd;
  // Length of the phase in progress, and of the last high phase
  logic [7:0] run, hi_len;
  // Phase tracker; restarts on power loss so a cut-short phase is never judged
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_power_good_in) begin
      xd <= 1'b0;
      run <= 8'h0;
      hi_len <= 8'h0;
    end else begin
      xd <= o_expansion_bus_clock;
      run <= (o_expansion_bus_clock != xd) ? 8'h1 : run + 8'h1;
      if (xd && !o_expansion_bus_clock) hi_len <= run;
    end
  end
  chk_bus_reset_follow: assert property (1'b1 |=> o_bus_reset == !$past(i_power_good_in))
    else $error("bus reset does not follow power good");
  chk_power_local_reset: assert property (!i_power_good_in |=> o_local_cpu_reset_out)
    else $error("local reset low while power bad");
  chk_event_local_pulse: assert property (i_power_good_in && !o_local_cpu_reset_out &&
    i_kbc_fast_reset |=> o_local_cpu_reset_out[*8]) else $error("fast reset pulse missing");
  chk_bus_clock_toggle: assert property ($rose(i_double_rate_clock_in) && !$past(i_rst)
    |-> ##[1:2] $changed(o_bus_clock_out)) else $error("bus clock missed a toggle");
  chk_kbc_clock_toggle: assert property ($rose(i_ref_oscillator_in) && !$past(i_rst) &&
    $past(i_power_good_in) ##0 i_power_good_in[*3]
    |-> o_kbc_half_osc_clock != $past(o_kbc_half_osc_clock, 2))
    else $error("keyboard clock missed a toggle");
  chk_exp_phase_range: assert property (o_expansion_bus_clock != xd && hi_len != 8'h0
    |-> run >= 8'h1 && run <= 8'h8) else $error("expansion phase out of range");
  chk_exp_equal_phases: assert property (o_expansion_bus_clock && !xd && hi_len != 8'h0
    |-> run == hi_len) else $error("expansion clock phases unequal");
  chk_strap_follow: assert property (!i_power_good_in |=> o_strap_cfg == $past(i_straps))
    else $error("strap latch not sampling");
  chk_strap_hold: assert property (i_power_good_in |=> $stable(o_strap_cfg))
    else $error("strap latch changed after power good");
  cover property ($fell(o_local_cpu_reset_out));
  cover property ($rose(i_power_good_in));
  cover property (o_expansion_bus_clock && !xd && hi_len == 8'h3);
endmodule
bind rcs_top rcs_checker u_chk (.i_sys_clk, .i_rst, .i_power_good_in, .i_double_rate_clock_in,
  .i_ref_oscillator_in, .i_straps, .i_kbc_fast_reset, .o_bus_reset, .o_local_cpu_reset_out,
  .o_bus_clock_out, .o_kbc_half_osc_clock, .o_expansion_bus_clock, .o_strap_cfg);

// *** rcs_board.sv ***
`timescale 1ns/1ps
module rcs_board (
  input wire logic i_sys_clk,
  input wire logic i_supply_on,
  input wire logic [7:0] i_fit,
  output logic o_pg,
  output rcs_pkg::rcs_strap_t o_straps
);
  // Supply settling count before power good rises
  logic [3:0] settle = 4'h0;
  // Pins turn into chip outputs after power good, so their level wanders
  logic tog = 1'b0;
  // Settling and pin churn
  always_ff @(posedge i_sys_clk) begin
    tog <= ~tog;
    if (!i_supply_on) settle <= 4'h0;
    else if (settle != 4'hf) settle <= settle + 4'h1;
  end
  assign o_pg = (settle == 4'hf);
  // Pull levels, with resistors swapped where i_fit is set
  assign o_straps = (rcs_pkg::STRAP_DEFAULT ^ i_fit) ^ (o_pg ? {8{tog}} : 8'h00);
endmodule

// *** rcs_top_bench.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module rcs_top_bench;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, sup = 1'b0, dr = 1'b0, osc = 1'b0;
  logic acc = 1'b0, kfr = 1'b0, sdn = 1'b0, pg, ack, brst, lrst, bck, kck, xck, bp, kp;
  logic [23:0] ca = 24'h0;
  logic [11:0] adr = 12'h0;
  logic [31:0] wd = 32'h0, rd, got, e34, e35;
  logic [7:0] fit = 8'h0;
  logic [23:0] at [4] = '{24'h11ffff, 24'h120000, 24'h13ffff, 24'h140000};
  rcs_pkg::rcs_strap_t sp, cfg;
  int mismatches = 0, total_checks = 0, cyc_n = 0, n, h, nb, nk;
  initial begin
    forever #5 clk = ~clk;
  end
  rcs_board BRD (.i_sys_clk(clk), .i_supply_on(sup), .i_fit(fit), .o_pg(pg), .o_straps(sp));
  rcs_top DUT (.i_sys_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wd), .o_wb_dat(rd), .o_wb_ack(ack),
    .i_power_good_in(pg), .i_double_rate_clock_in(dr), .i_ref_oscillator_in(osc),
    .i_straps(sp), .i_cpu_access(acc), .i_cpu_addr(ca), .i_kbc_fast_reset(kfr),
    .i_shutdown_cycle(sdn), .o_bus_reset(brst), .o_local_cpu_reset_out(lrst),
    .o_bus_clock_out(bck), .o_kbc_half_osc_clock(kck), .o_expansion_bus_clock(xck),
    .o_strap_cfg(cfg));
  // Slow input clocks and hang guard; 2x period 4 cycles, oscillator 6
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n % 2 == 1) dr <= ~dr;
    if (cyc_n % 3 == 2) osc <= ~osc;
    if (cyc_n == 20000) begin
      mismatches++;
      conclude();
    end
  end
  // One classic bus cycle; released only at the edge that sees ack
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= {2'b00, idx, 2'b00};
    wd <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    got = rd;
    cyc <= 1'b0;
    `CHK("ack", 1'b1, ack)
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] e, input string nm);
    wb(1'b0, idx, 8'h00);
    `CHK(nm, e, got)
  endtask
  // One-cycle event: 0 access, 1 fast keyboard reset, 2 shutdown
  task automatic pulse(input int k, input logic [23:0] a);
    @(posedge clk);
    ca <= a;
    acc <= (k == 0);
    kfr <= (k == 1);
    sdn <= (k == 2);
    @(posedge clk);
    acc <= 1'b0;
    kfr <= 1'b0;
    sdn <= 1'b0;
  endtask
  // High phase of the expansion clock, counted from a fresh rising edge
  task automatic half();
    n = 0;
    h = 0;
    // Skip a period that may have started before the new speed was seen
    @(posedge clk);
    while (xck !== 1'b0 && n < 40) begin @(posedge clk); n++; end
    while (xck !== 1'b1 && n < 80) begin @(posedge clk); n++; end
    while (xck === 1'b1 && h < 40) begin @(posedge clk); h++; end
  endtask
  // Power cycle with a chosen strap fit, then read back the latch
  task automatic pwr(input logic [7:0] f);
    rcs_pkg::rcs_strap_t s;
    s = rcs_pkg::STRAP_DEFAULT ^ f;
    @(posedge clk);
    sup <= 1'b0;
    fit <= f;
    repeat (30) @(posedge clk);
    `CHK("follow", s, cfg)
    `CHK("bus_rst_on", 1'b1, brst)
    `CHK("kbc_off", 1'b0, kck)
    sup <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK("bus_rst_off", 1'b0, brst)
    `CHK("lrst_held", 1'b1, lrst)
    `CHK("held", s, cfg)
    e34 = {26'h0, s.strap_supply_level, 1'b0, s.strap_mode_aux, s.strap_rtc_enable, 1'b0,
      s.strap_pinout_mode};
    e35 = {24'h0, s.strap_rom_select, s.strap_normal_b, s.strap_kbc_enable, 3'h0,
      s.strap_parity_enable, 1'b0};
    rchk(8'h34, e34, "strap_a");
    rchk(8'h35, e35, "strap_b");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    pwr(8'h00);
    repeat (100) @(posedge clk);
    `CHK("lrst_done", 1'b0, lrst)
    rchk(8'h1e, 32'h0, "norm");
    rchk(8'h1f, 32'h7, "fast");
    rchk(8'h40, 32'hff, "lo");
    rchk(8'h20, 32'h0, "unmapped");
    wb(1'b1, 8'h34, 8'hff);
    rchk(8'h34, e34, "read_only");
    rchk(8'h43, 32'h1, "cause_pwr");
    wb(1'b1, 8'h43, 8'h0f);
    // Internal reset sources, the last one by software
    for (int k = 1; k < 4; k++) begin
      if (k < 3) pulse(k, 24'h0);
      else wb(1'b1, 8'h42, 8'h01);
      repeat (3) @(posedge clk);
      `CHK("lrst_src", 1'b1, lrst)
      repeat (110) @(posedge clk);
      `CHK("lrst_end", 1'b0, lrst)
      rchk(8'h43, 32'h1 << k, "cause");
      wb(1'b1, 8'h43, 8'h0f);
    end
    // All eight rates, changed while running
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, 8'h1e, k[7:0]);
      half();
      `CHK("rate", 8 - k, h)
    end
    wb(1'b1, 8'h1e, 8'h00);
    wb(1'b1, 8'h40, 8'h12);
    wb(1'b1, 8'h41, 8'h13);
    wb(1'b1, 8'h1f, 8'h05);
    // Range edges pick fast or normal
    for (int k = 0; k < 4; k++) begin
      pulse(0, at[k]);
      half();
      `CHK("speed", (at[k][23:16] >= 8'h12 && at[k][23:16] <= 8'h13) ? 3 : 8, h)
    end
    bp = bck;
    kp = kck;
    nb = 0;
    nk = 0;
    repeat (84) begin
      @(posedge clk);
      nb += (bck !== bp);
      nk += (kck !== kp);
      bp = bck;
      kp = kck;
    end
    `CHK("bus_clk", 21, nb)
    `CHK("kbc_clk", 14, nk)
    pwr(8'hff);
    conclude();
  end
endmodule
